// ==== dv/addr_shared_io_port_bench.sv ====
// Purpose: self-checking bench of the shared address/io port
// Assumes: 50 ns clock, registers at four times their index
// Notes: each of modes 1 to 7 is run from its own reset
`timescale 1ns/1ps
`default_nettype none
module addr_shared_io_port_bench;
   import asp_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic hw_standby = 0, sw_standby = 0, awready, wready, bvalid, arready, rvalid;
   logic [15:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   asp_mode_t mode = 3'h1;
   asp_byte_t ext_addr_hi = 0, pin_in, pin_out, pin_oe, pullup_on, ext_val = 0, ext_en = 0;
   logic [7:0] dm, qm, pm, po, oe;
   int n_errors = 0, n_checks = 0;
   localparam logic [15:0] A_DIR = 16'hff04, A_DAT = 16'hff0c, A_PUL = 16'hff60;
   asp_port u_asp_port (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .mode, .hw_standby, .sw_standby, .ext_addr_hi, .pin_in,
      .pin_out, .pin_oe, .pullup_on);
   asp_pins_model u_pins (.aclk, .pin_out, .pin_oe, .pullup_on, .ext_val, .ext_en, .pin_in);
   // ==========================================================
   // helpers
   initial
   begin
      forever #25 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ah, wh;
      ah = 0;
      wh = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ah && wh))
      begin
         @(posedge aclk);
         if (awvalid === 1 && awready === 1)
         begin
            ah = 1;
            awvalid <= 0;
         end
         if (wvalid === 1 && wready === 1)
         begin
            wh = 1;
            wvalid <= 0;
         end
      end
      while (bvalid !== 1) @(posedge aclk);
      bready <= 0;
      chk(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (rvalid !== 1)
      begin
         @(posedge aclk);
         if (arready === 1) arvalid <= 0;
      end
      rready <= 0;
      chk(rdata, {24'h00_0000, e});
      chk(32'(rresp), 32'(er));
   endtask
   // ==========================================================
   // tests
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      complete_run();
   end
   initial
   begin
      void'($urandom(32'h7689));
      for (int m = 1; m < 8; m++)
      begin
         aresetn <= 0;
         mode <= 3'(m);
         ext_en <= 8'hff;
         repeat (6) @(posedge aclk);
         aresetn <= 1;
         dm = (m < 5) ? 8'hff : 8'h00;
         repeat (3) @(posedge aclk);
         chk(32'(pin_oe), 32'(dm));
         rd(A_DIR, 8'hff, 2'b00);
         rd(A_DAT, ~dm & ext_val, 2'b00);
         rd(A_PUL, 8'h00, 2'b00);
         qm = 8'($urandom);
         pm = 8'($urandom);
         po = 8'($urandom);
         wr(A_DIR, po, 2'b00);
         if (m > 4) dm = po;
         wr(A_DAT, qm, 2'b00);
         wr(A_PUL, pm, 2'b00);
         wr(16'h0100, 8'h5a, 2'b10);
         ext_addr_hi <= 8'($urandom);
         ext_val <= 8'($urandom);
         ext_en <= 8'($urandom) | ~((m > 4) ? pm : 8'h00);
         repeat (3) @(posedge aclk);
         chk(32'(pin_oe), 32'(dm));
         chk(32'(pin_out & dm), 32'(((m == 7) ? qm : ext_addr_hi) & dm));
         chk(32'(pullup_on), 32'((m > 4) ? (pm & ~dm) : 8'h00));
         rd(A_DIR, 8'hff, 2'b00);
         rd(A_DAT, (qm & dm) | (~dm & ((ext_en & ext_val) | ~ext_en)), 2'b00);
         rd(A_PUL, pm, 2'b00);
         wstrb <= 4'h0;
         wr(A_PUL, ~pm, 2'b00);
         wstrb <= 4'hf;
         rd(A_PUL, pm, 2'b00);
         rd(16'h0100, 8'h00, 2'b10);
         sw_standby <= 1;
         repeat (3) @(posedge aclk);
         po = pin_out;
         oe = pin_oe;
         ext_addr_hi <= ~ext_addr_hi;
         qm = ~qm;
         wr(A_DAT, qm, 2'b00);
         repeat (3) @(posedge aclk);
         chk(32'({pin_out, pin_oe}), 32'({po, oe}));
         sw_standby <= 0;
         rd(A_PUL, pm, 2'b00);
         rd(A_DAT, (qm & dm) | (~dm & ((ext_en & ext_val) | ~ext_en)), 2'b00);
         hw_standby <= 1;
         ext_en <= 8'hff;
         repeat (3) @(posedge aclk);
         chk(32'(pullup_on), 32'h0000_0000);
         hw_standby <= 0;
         dm = (m < 5) ? 8'hff : 8'h00;
         repeat (3) @(posedge aclk);
         chk(32'(pin_oe), 32'(dm));
         rd(A_DAT, ~dm & ext_val, 2'b00);
         rd(A_PUL, 8'h00, 2'b00);
         $display("mode %0d done", m);
      end
      complete_run();
   end
endmodule
`default_nettype wire

// ==== dv/asp_pins_model.sv ====
// Purpose: pin-side partner of the shared address/io port
// Assumes: one pin level per bit, resolved each cycle
// Notes: a floating pin shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pin resolution
module asp_pins_model
(
   input wire logic aclk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_on,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_in
);
   logic [7:0] last_q = 8'h00;
   // device drive wins, then outside driver, then pull-up
   always_comb
   begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
         | (~pin_oe & ~ext_en & (pullup_on | ~last_q));
   end
   always_ff @(posedge aclk)
   begin
      last_q <= pin_in;
   end
endmodule
`default_nettype wire

// ==== dv/asp_port_asserts.sv ====
// Purpose: port-level checks of the shared address/io port
// Assumes: pin outputs registered one cycle behind
// Notes: bound into asp_port
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker
module asp_port_asserts
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire asp_pkg::asp_mode_t mode,
   input wire logic hw_standby,
   input wire logic sw_standby,
   input wire asp_pkg::asp_byte_t ext_addr_hi,
   input wire asp_pkg::asp_byte_t pin_out,
   input wire asp_pkg::asp_byte_t pin_oe,
   input wire asp_pkg::asp_byte_t pullup_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_addr_mode_drive: assert property ($past(aresetn) && !$past(sw_standby)
      && !$past(hw_standby) && mode inside {[1:4]}
      |-> pin_oe == 8'hff && pin_out == $past(ext_addr_hi)) else $error("address drive wrong");
   a_pull_low_off: assert property (mode inside {[1:4]} |-> pullup_on == 8'h00)
      else $error("pull-up on in address mode");
   a_pull_reset_off: assert property (disable iff (1'b0) !aresetn |=>
      pullup_on == 8'h00 && pin_oe == 8'h00) else $error("pins active after reset");
   a_pull_hw_off: assert property (hw_standby |=> pullup_on == 8'h00)
      else $error("pull-up on in hardware standby");
   a_pull_no_out: assert property (!sw_standby && !$past(sw_standby)
      |-> (pullup_on & pin_oe) == 8'h00) else $error("pull-up on a driven pin");
   a_standby_hold: assert property ($past(sw_standby) && $past(sw_standby, 2)
      |-> $stable(pin_out) && $stable(pin_oe)) else $error("drive moved in standby");
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |=> bvalid) else $error("write answer late");
   a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
      else $error("read answer late");
   a_resp_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("read upper bits set");
endmodule
bind asp_port asp_port_asserts u_asp_port_asserts (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .arvalid, .rvalid, .rready, .rdata, .mode,
   .hw_standby, .sw_standby, .ext_addr_hi, .pin_out, .pin_oe, .pullup_on);
`default_nettype wire

// ==== pkg/asp_consts.svh ====
// Purpose: constants for the shared address/io port
// Assumes: 16-bit register addresses over a 32-bit AXI4-Lite bus
// Notes: offsets are word indexes; the address is the low sixteen bits of four times the offset
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
// ==========================================================
// register map
`define ASP_OFF_DIR 16'hFFC1
`define ASP_OFF_DATA 16'hFFC3
`define ASP_OFF_PULL 16'hFFD8
`define ASP_BYTE_ADDR(o) {o[15:0], 2'b00}
// ==========================================================
// reset values and response codes
`define ASP_DIR_RST_ADDR 8'hFF
`define ASP_ZERO8 8'h00
`define ASP_ONES8 8'hFF
`define ASP_RESP_OKAY 2'b00
`define ASP_RESP_SLVERR 2'b10
`define ASP_MODE_RST 3'h7
`endif

// ==== pkg/asp_pkg.sv ====
// Purpose: types for the shared address/io port
// Assumes: nothing beyond the constants header
// Notes: one-hot codes for the bus slave states
package asp_pkg;
   typedef logic [7:0] asp_byte_t;
   typedef logic [2:0] asp_mode_t;
   typedef enum logic [2:0]
   {
      ASP_IDLE = 3'b001,
      ASP_RESP = 3'b010,
      ASP_WAIT = 3'b100
   } asp_state_t;
endpackage

// ==== rtl/asp_pin_mux.sv ====
// Purpose: per-pin function selection and pull-up gating
// Assumes: registers outside, outputs registered in the top
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module asp_pin_mux
(
   input wire logic [2:0] mode,
   input wire logic in_reset,
   input wire logic hw_standby,
   input wire logic [7:0] dir,
   input wire logic [7:0] data,
   input wire logic [7:0] pull,
   input wire logic [7:0] addr_hi,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pullup_on
);
   logic addr_mode;
   logic single_chip;
   always_comb
   begin
      addr_mode = (mode != 3'd0) && (mode <= 3'd4);
      single_chip = (mode == 3'd7);
      // bit n drives pin n only
      for (int n = 0; n < 8; n++)
      begin
         if (addr_mode)
         begin
            pin_out[n] = addr_hi[n];
            pin_oe[n] = 1'b1;
            pullup_on[n] = 1'b0;
         end
         else
         begin
            // mode 7 gives gpio, modes 0, 5 and 6 address
            pin_out[n] = single_chip ? data[n] : addr_hi[n];
            pin_oe[n] = dir[n];
            // forced off in reset and hardware standby
            pullup_on[n] = !in_reset && !hw_standby && !dir[n] && pull[n];
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/asp_port.sv ====
// Purpose: eight-pin port shared with the upper address byte
// Assumes: AXI4-Lite slave, mode pins steady while running
// Notes: pin_out/pin_oe/pullup_on are registered, one cycle behind
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module asp_port
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [15:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire asp_pkg::asp_mode_t mode,
   input wire logic hw_standby,
   input wire logic sw_standby,
   input wire asp_pkg::asp_byte_t ext_addr_hi,
   input wire asp_pkg::asp_byte_t pin_in,
   output asp_pkg::asp_byte_t pin_out,
   output asp_pkg::asp_byte_t pin_oe,
   output asp_pkg::asp_byte_t pullup_on
);
   import asp_pkg::*;

   // ==========================================================
   // decode helpers
   function automatic logic addr_is(input logic [15:0] a, input logic [15:0] off);
      addr_is = (a == {off[13:0], 2'b00});
   endfunction

   function automatic logic addr_mode_of(input asp_mode_t m);
      addr_mode_of = (m != 3'd0) && (m <= 3'd4);
   endfunction

   // ==========================================================
   // registers
   asp_byte_t dir_q, dir_d;
   asp_byte_t data_q, data_d;
   asp_byte_t pull_q, pull_d;
   asp_byte_t out_q, out_d;
   asp_byte_t oe_q, oe_d;
   asp_byte_t pu_q, pu_d;
   asp_byte_t mux_out, mux_oe, mux_pu;
   logic in_reset_q, in_reset_d;

   // ==========================================================
   // bus slave state
   asp_state_t wst_q, wst_d;
   logic aw_got_q, aw_got_d;
   logic w_got_q, w_got_d;
   logic [15:0] waddr_q, waddr_d;
   logic [31:0] wbuf_q, wbuf_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d;
   logic bvalid_q, bvalid_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [15:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic do_write;

   asp_pin_mux u_mux
   (
      .mode(mode),
      .in_reset(in_reset_q),
      .hw_standby(hw_standby),
      .dir(dir_q),
      .data(data_q),
      .pull(pull_q),
      .addr_hi(ext_addr_hi),
      .pin_out(mux_out),
      .pin_oe(mux_oe),
      .pullup_on(mux_pu)
   );

   // ==========================================================
   // write channel: address and data taken in either order
   always_comb
   begin
      wst_d = wst_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      waddr_d = waddr_q;
      wbuf_d = wbuf_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      bvalid_d = bvalid_q;
      do_write = 1'b0;
      wa = aw_got_q ? waddr_q : awaddr;
      wd = w_got_q ? wbuf_q : wdata;
      ws = w_got_q ? wstrb_q : wstrb;
      case (wst_q)
         ASP_IDLE:
         begin
            if (awvalid && !aw_got_q)
            begin
               aw_got_d = 1'b1;
               waddr_d = awaddr;
            end
            if (wvalid && !w_got_q)
            begin
               w_got_d = 1'b1;
               wbuf_d = wdata;
               wstrb_d = wstrb;
            end
            if ((awvalid || aw_got_q) && (wvalid || w_got_q))
            begin
               do_write = 1'b1;
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               bvalid_d = 1'b1;
               if (addr_is(wa, `ASP_OFF_DIR) || addr_is(wa, `ASP_OFF_DATA)
                   || addr_is(wa, `ASP_OFF_PULL))
                  bresp_d = `ASP_RESP_OKAY;
               else
                  bresp_d = `ASP_RESP_SLVERR;
               wst_d = ASP_RESP;
            end
         end
         ASP_RESP:
         begin
            if (bready)
            begin
               bvalid_d = 1'b0;
               wst_d = ASP_IDLE;
            end
         end
         default:
         begin
            wst_d = ASP_IDLE;
            bvalid_d = 1'b0;
         end
      endcase
      // ready computed from the next state so both outputs come straight off flops
      awready_d = (wst_d == ASP_IDLE) && !aw_got_d;
      wready_d = (wst_d == ASP_IDLE) && !w_got_d;
   end

   // ==========================================================
   // register writes; software standby changes nothing, so contents are kept
   always_comb
   begin
      dir_d = dir_q;
      data_d = data_q;
      pull_d = pull_q;
      in_reset_d = 1'b0;
      if (hw_standby)
      begin
         // hardware standby initialises like reset
         dir_d = addr_mode_of(mode) ? `ASP_DIR_RST_ADDR : `ASP_ZERO8;
         data_d = `ASP_ZERO8;
         pull_d = `ASP_ZERO8;
      end
      else
      begin
         if (addr_mode_of(mode))
            dir_d = `ASP_ONES8;
         else if (do_write && ws[0] && addr_is(wa, `ASP_OFF_DIR))
            dir_d = wd[7:0];
         if (do_write && ws[0] && addr_is(wa, `ASP_OFF_DATA))
            data_d = wd[7:0];
         if (do_write && ws[0] && addr_is(wa, `ASP_OFF_PULL))
            pull_d = wd[7:0];
      end
   end

   // ==========================================================
   // read channel
   always_comb
   begin
      arready_d = 1'b0;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && rready)
         rvalid_d = 1'b0;
      if (!rvalid_q && arvalid && !arready_q)
      begin
         arready_d = 1'b1;
         rvalid_d = 1'b1;
         rresp_d = `ASP_RESP_OKAY;
         if (addr_is(araddr, `ASP_OFF_DIR))
            rdata_d = {24'h00_0000, `ASP_ONES8};
         else if (addr_is(araddr, `ASP_OFF_DATA))
            rdata_d = {24'h00_0000, (dir_q & data_q) | (~dir_q & pin_in)};
         else if (addr_is(araddr, `ASP_OFF_PULL))
            rdata_d = {24'h00_0000, pull_q};
         else
         begin
            rdata_d = 32'h0000_0000;
            rresp_d = `ASP_RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // pins: software standby freezes the driven state
   always_comb
   begin
      out_d = sw_standby ? out_q : mux_out;
      oe_d = sw_standby ? oe_q : mux_oe;
      pu_d = mux_pu;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_q <= ASP_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= 16'h0000;
         wbuf_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= `ASP_RESP_OKAY;
         bvalid_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `ASP_RESP_OKAY;
         // direction reset value follows the mode pins
         dir_q <= addr_mode_of(mode) ? `ASP_DIR_RST_ADDR : `ASP_ZERO8;
         data_q <= `ASP_ZERO8;
         pull_q <= `ASP_ZERO8;
         out_q <= `ASP_ZERO8;
         oe_q <= `ASP_ZERO8;
         pu_q <= `ASP_ZERO8;
         in_reset_q <= 1'b1;
      end
      else
      begin
         wst_q <= wst_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         waddr_q <= waddr_d;
         wbuf_q <= wbuf_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
         bvalid_q <= bvalid_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         dir_q <= dir_d;
         data_q <= data_d;
         pull_q <= pull_d;
         out_q <= out_d;
         oe_q <= oe_d;
         pu_q <= pu_d;
         in_reset_q <= in_reset_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign pullup_on = pu_q;
endmodule
`default_nettype wire
